// *** include/psc_pkg.sv ***
package psc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned SYS_CLK_MHZ     = 100;
  // Status held low this long after the request rises (limit is 40 us)
  localparam int unsigned STATUS_REL_US   = 10;
  // Reset time-out before an automatic restart after an error
  localparam int unsigned ERR_TIMEOUT_US  = 40;
  localparam int unsigned OSC_MHZ         = 10;
  // Initialization clocks from either source; 136 at 10 MHz is 13.6 us
  localparam int unsigned INIT_CLOCKS     = 136;

  localparam int unsigned TIMER_W = 13;
  localparam int unsigned INIT_W  = 8;
  localparam int unsigned DIV_W   = 4;

  localparam logic [TIMER_W-1:0] STATUS_REL_CYCLES =
    TIMER_W'(STATUS_REL_US * SYS_CLK_MHZ);
  localparam logic [TIMER_W-1:0] ERR_TIMEOUT_CYCLES =
    TIMER_W'(ERR_TIMEOUT_US * SYS_CLK_MHZ);
  localparam logic [DIV_W-1:0]   OSC_DIV_LAST =
    DIV_W'(SYS_CLK_MHZ / OSC_MHZ - 1);
  localparam logic [INIT_W-1:0]  INIT_LAST = INIT_W'(INIT_CLOCKS - 1);

  // ==========================================================================
  // Stream format
  // ==========================================================================
  // First byte of every stream; the last byte is the XOR of all before it
  localparam logic [7:0] SYNC_BYTE = 8'h6a;
  localparam int unsigned BYTE_CNT_W = 16;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_RESET, ST_WAIT_REL, ST_SETTLE, ST_LOAD, ST_ERROR, ST_INIT, ST_USER
  } psc_state_t;

  // Open-drain pin: out is always low, oe high pulls the line low
  typedef struct packed {
    logic out;
    logic oe;
  } psc_od_t;

  // Options carried in the stream settings, presented as static levels
  typedef struct packed {
    logic auto_restart;
    logic user_clk_sel;
    logic init_done_en;
  } psc_opts_t;

endpackage : psc_pkg

// *** rtl/psc_link_rx.sv ***
module psc_link_rx (
  input  wire logic       link_clk,
  input  wire logic       link_run_n,
  input  wire logic       data_in,
  output logic [7:0]      byte_data,
  output logic            byte_toggle
);
  import psc_pkg::*;

  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;

  // ==========================================================================
  // Byte assembly on the link clock
  // ==========================================================================
  // Held in reset whenever the system side stops loading. Release is not
  // synchronised: the host leaves at least 1 us between release and its
  // first edge, so no edge can race the release.
  always_ff @(posedge link_clk or posedge link_run_n) begin
    if (link_run_n) begin
      shift_reg   <= 7'h00;
      bit_cnt_reg <= 3'h0;
      byte_data   <= 8'h00;
      byte_toggle <= 1'b0;
    end else begin
      shift_reg   <= {data_in, shift_reg[6:1]};       // RQ4 RQ22
      bit_cnt_reg <= bit_cnt_reg + 3'h1;              // RQ3
      if (bit_cnt_reg == 3'h7) begin
        byte_data   <= {data_in, shift_reg};          // RQ4
        byte_toggle <= ~byte_toggle;
      end
    end
  end

  // Byte stays stable for 8 link periods, far longer than the crossing
  a_byte_held: assert property ( // RQ22
    @(posedge link_clk) disable iff (link_run_n)
    (bit_cnt_reg != 3'h7) |=> $stable(byte_data))
    else $error("byte changed mid-byte");

endmodule : psc_link_rx

// *** rtl/psc_loader.sv ***
// Notes on behaviour
// RQ1: Host starts an attempt with a rising edge on config request.
// RQ2: Status released after request rises; loading waits for the line high.
// RQ3: Host sends one data bit per serial clock cycle.
// RQ4: Each byte arrives least significant bit first.
// RQ5: Bits keep being accepted until the done line goes high.
// RQ6: A clean full stream releases the done line and starts init.
// RQ7: Default init runs on a 10 MHz oscillator, stopped afterwards.
// RQ8: With user clock, host supplies 136 further clocks after the data.
// RQ9: Serial clock activity after configuration is ignored.
// RQ10: No handshake; serial clock may stop indefinitely without loss.
// RQ11: Host keeps serial clock at or below the maximum rate.
// RQ12: A detected error drives the status line low.
// RQ13: Host may restart by pulsing the request low.
// RQ14: Auto-restart releases status after a time-out; host resends.
// RQ15: Host reconfigures if done and init-done fail to rise.
// RQ16: Init-done pin is driven only when its option is enabled.
// RQ17: Without init-done, host waits the done-to-user-mode delay.
// RQ18: Host never drives the done line low before user mode.
// RQ19: Host keeps user clock toggling while status is low, 40 us.
// RQ20: Init waits until the shared done line is high.
// RQ21: Shared status line pulled low halts this device's loading.
// RQ22: Data sampled on rising serial clock; host gives 7 ns setup.
// RQ23: Host keeps serial clock at or below 100 MHz.
// RQ24: User mode 6 to 20 us after done, or 136 user clocks.
// RQ25: After own configuration, chain-enable output is asserted.
// RQ26: Chain-enable input high ignores the link and holds output high.
module psc_loader #(
  parameter int unsigned STREAM_BYTES = 64
) (
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           serial_config_clock_in,
  input  wire logic           serial_config_data_in,
  input  wire logic           config_request_n,
  input  wire logic           status_in,
  input  wire logic           done_in,
  input  wire logic           user_clock_in,
  input  wire logic           chain_enable_in_n,
  input  wire psc_pkg::psc_opts_t options,
  output psc_pkg::psc_od_t    status_pin,
  output psc_pkg::psc_od_t    done_pin,
  output psc_pkg::psc_od_t    init_done_pin,
  output logic                chain_enable_out_n,
  output logic                user_mode
);
  import psc_pkg::*;

  localparam logic [BYTE_CNT_W-1:0] LAST_BYTE =
    BYTE_CNT_W'(STREAM_BYTES - 1);

  function automatic logic [TIMER_W-1:0] dec_sat(
    input logic [TIMER_W-1:0] v
  );
    dec_sat = (v == '0) ? v : v - TIMER_W'(1);
  endfunction : dec_sat

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Order: request, status, done, user clock, chain enable, byte toggle
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic       uclk_d_reg;
  logic       tog_d_reg;
  logic [7:0] link_byte;
  logic       link_toggle;
  logic       link_run_n_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Request starts at its asserted level so reset release is no start
      sync1_reg  <= 6'h00;
      sync2_reg  <= 6'h00;
      uclk_d_reg <= 1'b0;
      tog_d_reg  <= 1'b0;
    end else begin
      sync1_reg  <= {link_toggle, chain_enable_in_n, user_clock_in,
                     done_in, status_in, config_request_n};
      sync2_reg  <= sync1_reg;
      uclk_d_reg <= sync2_reg[3];
      tog_d_reg  <= sync2_reg[5];
    end
  end

  logic req_sync;
  logic status_sync;
  logic done_sync;
  logic chain_en;
  logic uclk_rise;
  logic byte_evt;

  assign req_sync    = sync2_reg[0];
  assign status_sync = sync2_reg[1];
  assign done_sync   = sync2_reg[2];
  assign chain_en    = ~sync2_reg[4];
  assign uclk_rise   = sync2_reg[3] & ~uclk_d_reg;
  assign byte_evt    = sync2_reg[5] ^ tog_d_reg;

  // ==========================================================================
  // Link side
  // ==========================================================================
  psc_link_rx u_link (
    .link_clk    (serial_config_clock_in),
    .link_run_n  (link_run_n_reg),
    .data_in     (serial_config_data_in),
    .byte_data   (link_byte),
    .byte_toggle (link_toggle)
  );

  // ==========================================================================
  // Stream checking
  // ==========================================================================
  psc_state_t            state_reg;
  psc_state_t            state_next;
  logic [BYTE_CNT_W-1:0] byte_cnt_reg;
  logic [7:0]            xor_reg;
  logic                  byte_ok;
  logic                  stream_end;

  // Byte is read a few cycles after its toggle; it holds for 8 link clocks
  always_comb begin
    byte_ok    = 1'b1;
    stream_end = 1'b0;
    if (byte_evt) begin
      if (byte_cnt_reg == '0 && link_byte != SYNC_BYTE)
        byte_ok = 1'b0;
      if (byte_cnt_reg == LAST_BYTE) begin
        stream_end = 1'b1;
        byte_ok    = (link_byte == xor_reg);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_reg <= '0;
      xor_reg      <= 8'h00;
    end else if (state_reg != ST_LOAD) begin
      byte_cnt_reg <= '0;
      xor_reg      <= 8'h00;
    end else if (byte_evt) begin
      byte_cnt_reg <= byte_cnt_reg + BYTE_CNT_W'(1);
      xor_reg      <= xor_reg ^ link_byte;
    end
  end

  // ==========================================================================
  // Timers and initialization clock
  // ==========================================================================
  logic [TIMER_W-1:0] timer_reg;
  logic [DIV_W-1:0]   div_reg;
  logic [INIT_W-1:0]  init_cnt_reg;
  logic               osc_run_reg;
  logic               init_tick;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= STATUS_REL_CYCLES;
    end else if (state_next == ST_WAIT_REL && state_reg != ST_WAIT_REL) begin
      timer_reg <= STATUS_REL_CYCLES;
    end else if (state_next == ST_ERROR && state_reg != ST_ERROR) begin
      timer_reg <= ERR_TIMEOUT_CYCLES;
    end else begin
      timer_reg <= dec_sat(timer_reg);
    end
  end

  // Internal oscillator modelled as a divided system clock; it only runs
  // while initialization is under way and is stopped afterwards.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_run_reg <= 1'b0;
      div_reg     <= '0;
    end else begin
      osc_run_reg <= (state_next == ST_INIT) & done_sync
                     & ~options.user_clk_sel;                   // RQ7 RQ20
      div_reg     <= (!osc_run_reg || div_reg == OSC_DIV_LAST) ?
                     '0 : div_reg + DIV_W'(1);
    end
  end

  assign init_tick = options.user_clk_sel ? uclk_rise               // RQ24
                   : (osc_run_reg && div_reg == OSC_DIV_LAST);      // RQ7

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_reg <= '0;
    end else if (state_reg != ST_INIT) begin
      init_cnt_reg <= '0;
    end else if (done_sync && init_tick) begin                      // RQ20
      init_cnt_reg <= init_cnt_reg + INIT_W'(1);
    end
  end

  // ==========================================================================
  // Configuration sequence
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET:
        if (req_sync) state_next = ST_WAIT_REL;
      ST_WAIT_REL:
        if (timer_reg == '0) state_next = ST_SETTLE;                // RQ2
      // A stale toggle from the last attempt must have settled to its
      // reset level first, or it would be counted as a byte
      ST_SETTLE:
        if (status_sync && chain_en && !sync2_reg[5] && !tog_d_reg)
          state_next = ST_LOAD;                           // RQ2 RQ26
      ST_LOAD:
        if (!status_sync || !chain_en) state_next = ST_SETTLE;  // RQ21 RQ26
        else if (!byte_ok) state_next = ST_ERROR;                   // RQ12
        else if (stream_end) state_next = ST_INIT;                  // RQ6
      ST_ERROR:
        if (options.auto_restart && timer_reg == '0)
          state_next = ST_SETTLE;                                   // RQ14
      ST_INIT:
        if (done_sync && init_tick && init_cnt_reg == INIT_LAST)
          state_next = ST_USER;                                     // RQ24
      ST_USER:
        state_next = ST_USER;
    endcase
    if (!req_sync) state_next = ST_RESET;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state_reg <= ST_RESET;
    else        state_reg <= state_next;
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // All outputs follow the next state so they line up with state_reg.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_pin         <= '{out: 1'b0, oe: 1'b1};
      done_pin           <= '{out: 1'b0, oe: 1'b1};
      init_done_pin      <= '{out: 1'b0, oe: 1'b0};
      chain_enable_out_n <= 1'b1;
      user_mode          <= 1'b0;
      link_run_n_reg     <= 1'b1;
    end else begin
      status_pin.oe  <= state_next inside {ST_RESET, ST_WAIT_REL,
                                           ST_ERROR};               // RQ2 RQ12
      done_pin.oe    <= !(state_next inside {ST_INIT, ST_USER});    // RQ5 RQ6
      init_done_pin.oe <= options.init_done_en
                          && state_next != ST_USER;                 // RQ16
      chain_enable_out_n <= !(chain_en && state_next inside
                                            {ST_INIT, ST_USER});    // RQ25 RQ26
      user_mode      <= (state_next == ST_USER);
      // Stopped link clock needs no care: the byte counter stays put
      link_run_n_reg <= !(state_next == ST_LOAD && chain_en);   // RQ9 RQ10 RQ26
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_load_after_rel: assert property ( // RQ2
    !link_run_n_reg |-> !status_pin.oe && $past(status_sync))
    else $error("loading while status is held low");

  a_done_release: assert property ( // RQ6
    (state_reg == ST_LOAD && stream_end && byte_ok && status_sync
     && req_sync && chain_en) |=> !done_pin.oe && init_cnt_reg == '0)
    else $error("done not released after clean stream");

  a_done_held: assert property ( // RQ5
    state_reg == ST_LOAD |-> done_pin.oe)
    else $error("done released during loading");

  a_osc_stopped: assert property ( // RQ7
    state_reg == ST_USER |=> !osc_run_reg)
    else $error("oscillator running in user mode");

  a_link_ignored: assert property ( // RQ9
    state_reg inside {ST_INIT, ST_USER} |-> link_run_n_reg)
    else $error("link active after configuration");

  a_error_drive: assert property ( // RQ12
    (state_reg == ST_LOAD && !byte_ok && status_sync && req_sync
     && chain_en) |=> status_pin.oe [*8])
    else $error("status not driven low on error");

  a_no_auto: assert property ( // RQ14
    (state_reg == ST_ERROR && !options.auto_restart && req_sync)
    |=> state_reg == ST_ERROR && status_pin.oe)
    else $error("left error state without restart option");

  a_auto_release: assert property ( // RQ14
    (state_reg == ST_ERROR && options.auto_restart && timer_reg == '0
     && req_sync) |=> !status_pin.oe)
    else $error("status not released after time-out");

  a_init_done_off: assert property ( // RQ16
    !options.init_done_en |=> !init_done_pin.oe)
    else $error("init-done driven while disabled");

  a_chain_wait: assert property ( // RQ20
    (state_reg == ST_INIT && !done_sync) |=> $stable(init_cnt_reg))
    else $error("init counted while shared done low");

  a_chain_halt: assert property ( // RQ21
    (state_reg == ST_LOAD && !status_sync && req_sync) |=> link_run_n_reg
    && state_reg == ST_SETTLE)
    else $error("loading continued with status low");

  a_user_entry: assert property ( // RQ24
    $rose(user_mode) |-> $past(init_cnt_reg) == INIT_LAST
    && $past(init_tick))
    else $error("user mode entered early");

  // The output was computed from the enable seen one edge earlier
  a_chain_out: assert property ( // RQ25 RQ26
    !chain_enable_out_n |-> $past(chain_en) && !done_pin.oe)
    else $error("chain enable out asserted too early");

  a_req_abort: assert property ( // RQ2
    !req_sync |=> status_pin.oe && done_pin.oe && !user_mode
    && link_run_n_reg)
    else $error("request low did not abort the attempt");

  a_chain_gate: assert property ( // RQ26
    !chain_en |=> link_run_n_reg && state_reg != ST_LOAD)
    else $error("loading while chain enable is off");

  a_init_released: assert property ( // RQ6
    state_reg == ST_INIT |-> !done_pin.oe && !status_pin.oe)
    else $error("done or status held low during init");

  a_user_pins: assert property ( // RQ16
    state_reg == ST_USER |-> !init_done_pin.oe && !done_pin.oe)
    else $error("init-done still held low in user mode");

  c_user_mode:   cover property ($rose(user_mode));
  c_error:       cover property (state_reg == ST_LOAD ##1
                                 state_reg == ST_ERROR);
  c_auto_retry:  cover property (state_reg == ST_ERROR ##1
                                 state_reg == ST_SETTLE);
  c_chain_halt:  cover property (state_reg == ST_LOAD && !status_sync);

endmodule : psc_loader

// *** test/psc_host_model.sv ***
module psc_host_model
  import psc_pkg::*;
(
  output logic link_clk,
  output logic link_data,
  output logic user_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_clk  = 1'b0;
    link_data = 1'b0;
    user_clk  = 1'b0;
  end

  // ==========================================================================
  // Serial link: 48 ns period, clock stands still between bytes
  // ==========================================================================
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      link_data = b[i];
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
    // Released line shows the inverse so a late sample cannot match; the
    // pause keeps a following byte from driving the line in the same step
    #4 link_data = ~b[7];
    #4;
  endtask : send_byte

  // ==========================================================================
  // User start-up clock, 100 ns period, well below half the system rate
  // ==========================================================================
  task automatic user_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #50 user_clk = 1'b1;
      #50 user_clk = 1'b0;
    end
  endtask : user_clocks
endmodule : psc_host_model

// *** test/testbench.sv ***
module testbench
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int NB = 4;

  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       config_request_n = 1'b0;
  logic       chain_in_n = 1'b0;
  logic       ext_status_low = 1'b0;
  logic       ext_done_low = 1'b0;
  psc_opts_t  opts = '0;
  psc_od_t    status_pin;
  psc_od_t    done_pin;
  psc_od_t    init_done_pin;
  logic       ceo_n;
  logic       user_mode;
  logic       link_clk;
  logic       link_data;
  logic       user_clk;
  logic [7:0] stream[$];
  int         seed = 32'h3dab;
  int         fails = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int         n;

  // Open-drain lines with pull-ups, shared with the far side
  wire logic status_line = ~(status_pin.oe | ext_status_low);
  wire logic done_line = ~(done_pin.oe | ext_done_low);

  always #5 sys_clk = ~sys_clk;

  psc_host_model host_inst (
    .link_clk  (link_clk),
    .link_data (link_data),
    .user_clk  (user_clk)
  );

  psc_loader #(.STREAM_BYTES(NB)) psc_loader_inst (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .serial_config_clock_in (link_clk),
    .serial_config_data_in  (link_data),
    .config_request_n       (config_request_n),
    .status_in              (status_line),
    .done_in                (done_line),
    .user_clock_in          (user_clk),
    .chain_enable_in_n      (chain_in_n),
    .options                (opts),
    .status_pin             (status_pin),
    .done_pin               (done_pin),
    .init_done_pin          (init_done_pin),
    .chain_enable_out_n     (ceo_n),
    .user_mode              (user_mode)
  );

  // ==========================================================================
  // Checking and reporting
  // ==========================================================================
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      $display("unexpected at %0t: time limit reached", $time);
      final_report();
    end
  end

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  function automatic logic probe(input int k);
    case (k)
      0: return status_pin.oe;
      1: return done_pin.oe;
      default: return user_mode;
    endcase
  endfunction : probe

  task automatic wait_for(input int k, input logic lvl, input int lim,
                          output int cnt);
    cnt = 0;
    while (probe(k) !== lvl && cnt < lim) begin
      tick();
      cnt++;
    end
  endtask : wait_for

  // ==========================================================================
  // Stream model: sync byte first, last byte is the XOR of all before it
  // ==========================================================================
  function automatic bit stream_ok();
    logic [7:0] x = 8'h00;
    for (int i = 0; i < stream.size() - 1; i++) x ^= stream[i];
    return stream[0] == SYNC_BYTE && stream[$] == x;
  endfunction : stream_ok

  task automatic send(input logic bad, input int pause);
    logic [7:0] x;
    stream = {SYNC_BYTE};
    x = SYNC_BYTE;
    for (int i = 1; i < NB - 1; i++) begin
      stream.push_back(8'($random(seed)));
      x ^= stream[$];
    end
    stream.push_back(bad ? ~x : x);
    foreach (stream[i]) begin
      host_inst.send_byte(stream[i]);
      if (i == 0) repeat (pause) tick();
    end
    tick();
  endtask : send

  task automatic run(input logic bad, input int pause);
    int c;
    send(bad, pause);
    if (stream_ok()) wait_for(1, 1'b0, 20, c);
    else wait_for(0, 1'b1, 20, c);
    check(done_pin.oe, !stream_ok(), "done line");
    check(status_pin.oe, !stream_ok(), "status line");
    check(ceo_n, !stream_ok(), "chain enable out");
  endtask : run

  // A request pulse, then status must stay low for the release delay
  task automatic start_cfg;
    int c;
    config_request_n = 1'b0;
    repeat (10) tick();
    config_request_n = 1'b1;
    wait_for(0, 1'b0, 3000, c);
    check(c >= STATUS_REL_CYCLES && c < 3000, 1, "status release");
    repeat (120) tick();
  endtask : start_cfg

  task automatic end_test(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask : end_test

  initial begin
    repeat (8) tick();
    rst_n = 1'b1;
    tick();
    check(status_pin.oe, 1, "status at reset");
    check(done_pin.oe, 1, "done at reset");
    check(ceo_n, 1, "chain out at reset");
    check(user_mode, 0, "user mode at reset");
    end_test("reset");
    start_cfg();
    run(1'b0, 500);
    check(init_done_pin.oe, 0, "init done disabled");
    wait_for(2, 1'b1, 2100, n);
    check(n >= 600 && n <= 2000, 1, "oscillator init time");
    host_inst.send_byte(8'($random(seed)));
    repeat (10) tick();
    check(done_pin.oe, 0, "late clocks on done");
    check(user_mode, 1, "late clocks on user mode");
    end_test("good stream");
    start_cfg();
    run(1'b1, 0);
    repeat (4500) tick();
    check(status_pin.oe, 1, "error stands");
    end_test("error");
    start_cfg();
    host_inst.send_byte(SYNC_BYTE);
    host_inst.send_byte(8'($random(seed)));
    ext_status_low = 1'b1;
    repeat (20) tick();
    ext_status_low = 1'b0;
    repeat (120) tick();
    run(1'b0, 0);
    end_test("chain halt");
    chain_in_n = 1'b1;
    start_cfg();
    send(1'b0, 0);
    repeat (20) tick();
    check(done_pin.oe, 1, "ignored while not enabled");
    check(ceo_n, 1, "chain out held");
    chain_in_n = 1'b0;
    repeat (120) tick();
    run(1'b0, 0);
    end_test("chain enable");
    opts = 3'b011;
    ext_done_low = 1'b1;
    start_cfg();
    run(1'b0, 0);
    host_inst.user_clocks(140);
    check(user_mode, 0, "init waits for done line");
    ext_done_low = 1'b0;
    repeat (5) tick();
    host_inst.user_clocks(130);
    check(user_mode, 0, "user mode early");
    check(init_done_pin.oe, 1, "init done held low");
    host_inst.user_clocks(6);
    wait_for(2, 1'b1, 10, n);
    check(user_mode, 1, "user clock init");
    check(init_done_pin.oe, 0, "init done released");
    end_test("user clock");
    opts = 3'b100;
    start_cfg();
    run(1'b1, 0);
    wait_for(0, 1'b0, 5000, n);
    check(n >= 3950 && n <= 4020, 1, "restart time-out");
    repeat (120) tick();
    run(1'b0, 0);
    check({status_pin.out, done_pin.out}, 0, "open-drain out");
    end_test("auto restart");
    final_report();
  end
endmodule : testbench
